// File: otmr_consts.svh
/*
  Constants for the overtemperature duration timer and tach pulse config.
  Assumes a 250 MHz clock and a register port driven by an upstream
  serial management bus engine.
*/
// Function
// - Status bit 0 sets when the overtemp line becomes asserted.
// - Reading the status register clears the assertion flag.
// - Past 45.52 ms, bit 0 becomes LSB of the 8-bit count.
// - Count steps every 22.76 ms, reporting up to 5.80 s.
// - Upper seven status bits read zero until 45.52 ms elapsed.
// - Read/write 8-bit duration limit, 22.76 ms per step.
// - Duration above limit sets the exceeded flag in interrupt status 2.
// - Limit 0x00 raises the flag immediately on assertion.
// - Per-fan 2-bit code selects 1 to 4 counted tach pulses.
// - Fan fields sit at bits 1:0, 3:2, 5:4 and 7:6.
// - Pulses-per-rev register resets to 0x55.
// - Status register resets to 0x00.
`ifndef OTMR_CONSTS_SVH
`define OTMR_CONSTS_SVH
`define OTMR_ADDR_STATUS 8'h79
`define OTMR_ADDR_LIMIT 8'h7A
`define OTMR_ADDR_PPR 8'h7B
`define OTMR_RST_STATUS 8'h00
`define OTMR_RST_LIMIT 8'h00
`define OTMR_RST_PPR 8'h55
`define OTMR_CLK_HZ 250000000
`define OTMR_STEP_NS 22760000
`define OTMR_STEP_CYC ((`OTMR_STEP_NS / 1000) * (`OTMR_CLK_HZ / 1000000))
`define OTMR_COUNT_MAX 8'hFF
`define OTMR_COUNT_SHOW 8'h02
`define OTMR_FLAG_BIT 0
`define OTMR_RST_PULSES 3'h2
`endif

// File: otmr_line_src.sv
/* Overtemp line source standing in for the sensing logic.
   Assumes the bench changes the request off the clock edge. */
module otmr_line_src (
  input wire logic hot_i,
  output logic line_o
);
  // Clean level that follows the request
  assign line_o = hot_i;
endmodule

// File: otmr_monitor.sv
/* Port checker for the overtemp duration timer.
   Assumes it is bound onto overtemp_duration_timer. */
module otmr_monitor (
  input wire logic clk_i, srst_i, reg_wr_i, overtemp_line_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire logic duration_exceeded_flag_o,
  input wire logic [2:0] first_fan_pulses_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Fan field follows a write two edges later
  property p_ppr;
    reg_wr_i && reg_addr_i == 8'h7B |-> ##2
      first_fan_pulses_o == 3'($past(reg_wdata_i, 2) & 8'h03) + 3'h1;
  endproperty
  a_ppr: assert property (p_ppr) else $error("fan count wrong");
  property p_rst;
    disable iff (1'b0) srst_i ##1 srst_i |=> first_fan_pulses_o == 3'h2;
  endproperty
  a_rst: assert property (p_rst) else $error("fan reset wrong");
  property p_once;
    duration_exceeded_flag_o |=> !duration_exceeded_flag_o;
  endproperty
  a_once: assert property (p_once) else $error("flag too long");
  property p_hot;
    duration_exceeded_flag_o |-> $past(overtemp_line_i);
  endproperty
  a_hot: assert property (p_hot) else $error("flag while cool");
  // Read data stands until the next read strobe
  property p_rdhold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("rdata moved");
  // Offsets outside the block read as zero
  property p_rdz;
    reg_rd_i && !(reg_addr_i inside {8'h79, 8'h7A, 8'h7B}) |=>
      reg_rdata_o == 8'h00;
  endproperty
  a_rdz: assert property (p_rdz) else $error("unmapped not zero");
  // Main scenarios reached
  c_flag: cover property (duration_exceeded_flag_o);
  c_rise: cover property ($rose(overtemp_line_i));
  c_ppr: cover property (reg_wr_i && reg_addr_i == 8'h7B);
endmodule
bind overtemp_duration_timer otmr_monitor i_otmr_monitor (.clk_i, .srst_i,
  .reg_wr_i, .overtemp_line_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o,
  .duration_exceeded_flag_o, .first_fan_pulses_o);

// File: otmr_pkg.sv
/*
  Types shared by the overtemperature duration timer.
  Assumes nothing beyond a SystemVerilog tool.
*/
package otmr_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] pulses_t;
endpackage

// File: overtemp_duration_timer.sv
/*
  Overtemperature assertion duration timer, duration limit and per-fan
  tach pulses-per-revolution configuration.
  Assumes a synchronous register port with one-cycle read and write
  strobes, and an overtemp line already synchronised, active high.
*/
`include "otmr_consts.svh"
module overtemp_duration_timer #(
  parameter int STEP_CYC = `OTMR_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Overtemperature input, high while asserted
  input wire logic overtemp_line_i,
  // Interrupt status 2 bit 5 set pulse and per-fan pulse counts
  output logic duration_exceeded_flag_o,
  output logic [2:0] first_fan_pulses_o,
  output logic [2:0] second_fan_pulses_o,
  output logic [2:0] third_fan_pulses_o,
  output logic [2:0] fourth_fan_pulses_o
);

  // Code 00..11 means 1..4 pulses
  function automatic otmr_pkg::pulses_t pulses(input logic [1:0] sel);
    pulses = {1'b0, sel} + 3'h1;
  endfunction

  logic line_d_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [7:0] elapsed_assert_count_r;
  logic assert_flag_r;
  logic [7:0] duration_limit_value_r;
  logic [7:0] ppr_r;
  logic rd_status;
  logic [7:0] status_view;
  logic exceeded_nxt;
  logic exceeded_seen_r;

  assign rd_status = reg_rd_i && (reg_addr_i == `OTMR_ADDR_STATUS);
  assign tick = overtemp_line_i && (tick_cnt_r == 32'(STEP_CYC - 1));

  // Previous line level for edge detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_d_r <= 1'b0;
    end else begin
      line_d_r <= overtemp_line_i;
    end
  end

  // Time base, restarted at each new assertion
  always_ff @(posedge clk_i) begin
    if (srst_i || !overtemp_line_i || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // Elapsed count over the current assertion, saturating
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      elapsed_assert_count_r <= `OTMR_RST_STATUS;
    end else if (overtemp_line_i && !line_d_r) begin
      elapsed_assert_count_r <= 8'h00;
    end else if (tick && elapsed_assert_count_r != `OTMR_COUNT_MAX) begin
      elapsed_assert_count_r <= elapsed_assert_count_r + 8'h01;
    end
  end

  // Assertion flag: set wins over clear on read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      assert_flag_r <= 1'b0;
    end else if (overtemp_line_i && !line_d_r) begin
      assert_flag_r <= 1'b1;
    end else if (rd_status) begin
      assert_flag_r <= 1'b0;
    end
  end

  // Flag only until two steps have elapsed, then the full count
  always_comb begin
    if (elapsed_assert_count_r >= `OTMR_COUNT_SHOW) begin
      status_view = elapsed_assert_count_r;
    end else begin
      status_view = {7'h00, assert_flag_r};
    end
  end

  // Writable registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      duration_limit_value_r <= `OTMR_RST_LIMIT;
      ppr_r <= `OTMR_RST_PPR;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `OTMR_ADDR_LIMIT) begin
        duration_limit_value_r <= reg_wdata_i;
      end
      if (reg_addr_i == `OTMR_ADDR_PPR) begin
        ppr_r <= reg_wdata_i;
      end
    end
  end

  // Read data, zero at unmapped offsets
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OTMR_ADDR_STATUS: reg_rdata_o <= status_view;
        `OTMR_ADDR_LIMIT: reg_rdata_o <= duration_limit_value_r;
        `OTMR_ADDR_PPR: reg_rdata_o <= ppr_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Limit exceeded; zero limit trips at assertion itself
  always_comb begin
    if (duration_limit_value_r == 8'h00) begin
      exceeded_nxt = overtemp_line_i;
    end else begin
      exceeded_nxt = overtemp_line_i &&
        (elapsed_assert_count_r > duration_limit_value_r);
    end
  end

  // One pulse toward interrupt status 2 on each rise of the exceeded condition
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exceeded_seen_r <= 1'b0;
      duration_exceeded_flag_o <= 1'b0;
    end else begin
      exceeded_seen_r <= exceeded_nxt;
      duration_exceeded_flag_o <= exceeded_nxt && !exceeded_seen_r;
    end
  end

  // Per-fan pulse counts
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      first_fan_pulses_o <= `OTMR_RST_PULSES;
      second_fan_pulses_o <= `OTMR_RST_PULSES;
      third_fan_pulses_o <= `OTMR_RST_PULSES;
      fourth_fan_pulses_o <= `OTMR_RST_PULSES;
    end else begin
      first_fan_pulses_o <= pulses(ppr_r[1:0]);
      second_fan_pulses_o <= pulses(ppr_r[3:2]);
      third_fan_pulses_o <= pulses(ppr_r[5:4]);
      fourth_fan_pulses_o <= pulses(ppr_r[7:6]);
    end
  end

endmodule

// File: overtemp_duration_timer_tb_top.sv
/* Bench: tach code table, then timer and access cases.
   Assumes a STEP_CYC of 10 cycles. */
module overtemp_duration_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, hot = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic overtemp_line_i, duration_exceeded_flag_o;
  logic [2:0] first_fan_pulses_o, second_fan_pulses_o;
  logic [2:0] third_fan_pulses_o, fourth_fan_pulses_o;
  int err_total = 0, check_count = 0, flag_n = 0, cyc = 0;
  logic [7:0] rows [4] = '{8'h00, 8'hE4, 8'h1B, 8'hFF};
  logic [11:0] outs [4] = '{12'h249, 12'h8D1, 12'h29C, 12'h924};
  wire [11:0] fans = {fourth_fan_pulses_o, third_fan_pulses_o,
    second_fan_pulses_o, first_fan_pulses_o};
  otmr_line_src i_otmr_line_src (.hot_i(hot), .line_o(overtemp_line_i));
  overtemp_duration_timer #(.STEP_CYC(10)) i_overtemp_duration_timer (
    .clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .overtemp_line_i, .duration_exceeded_flag_o,
    .first_fan_pulses_o, .second_fan_pulses_o, .third_fan_pulses_o,
    .fourth_fan_pulses_o);
  // Clock, flag pulse tally and hang guard
  always #2 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    if (duration_exceeded_flag_o === 1'b1) flag_n++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [11:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  // One strobe cycle, write when w is set
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    @(negedge clk_i);
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    acc(1'h0, a, 8'h00);
    chk("rdata", {4'h0, e}, {4'h0, reg_rdata_o});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    srst_i = 1'h0;
    chk("fans", 12'h492, fans);
    rd_chk(8'h7B, 8'h55);
    rd_chk(8'h79, 8'h00);
    for (int i = 0; i < 4; i++) begin
      acc(1'h1, 8'h7B, rows[i]);
      @(negedge clk_i);
      chk("fans", outs[i], fans);
      rd_chk(8'h7B, rows[i]);
    end
    $display("tach table done");
    hot = 1'h1;
    rd_chk(8'h79, 8'h01);
    repeat (10) @(negedge clk_i);
    rd_chk(8'h79, 8'h00);
    repeat (16) @(negedge clk_i);
    rd_chk(8'h79, 8'h03);
    chk("flags", 12'h001, 12'(flag_n));
    hot = 1'h0;
    acc(1'h1, 8'h7A, 8'h05);
    rd_chk(8'h7A, 8'h05);
    hot = 1'h1;
    repeat (55) @(negedge clk_i);
    chk("flags", 12'h001, 12'(flag_n));
    repeat (2545) @(negedge clk_i);
    hot = 1'h0;
    rd_chk(8'h79, 8'hFF);
    chk("flags", 12'h002, 12'(flag_n));
    acc(1'h1, 8'h79, 8'hAA);
    rd_chk(8'h79, 8'hFF);
    rd_chk(8'h50, 8'h00);
    acc(1'h1, 8'h7A, 8'hFF);
    rd_chk(8'h7A, 8'hFF);
    $display("timer cases done");
    stop_test();
  end
endmodule
